/* plw_watchdog.sv */
`timescale 1ns/1ps
//
// Contract
// (R01) counter overflow at selected point raises an internal reset
// (R02) watchdog reset sets cause flag bit 4
// (R03) oscillator source: overflow 2^11 to 2^18 cycles by code
// (R04) crystal source: overflow 2^13 to 2^20 cycles by code
// (R05) clock select 00 oscillator, 01 crystal, 1x stops
// (R06) mode register resets to 67H
// (R07) counting starts at release, longest oscillator interval
// (R08) mode register writable once; second write resets
// (R09) reset events while source gated wait until clock resumes
// (R10) software writes mode register bytewise only
// (R11) top bits written 0,1,1; others ignored when non-stoppable
// (R12) non-stoppable option ignores clock select, uses oscillator
// (R13) non-stoppable option never stops counting
// (R14) stoppable option: once stopped, stays stopped, no resets
// (R15) crystal source gated when stopped, standby, stabilising
// (R16) oscillator source gated in standby or osc stopped before STOP
// (R17) mode write inserts a wait cycle; software avoids subclock case
// (R18) key ACH to enable register clears counter
// (R19) wrong key or bit access to enable register resets
// (R20) enable register reads 9AH
// (R21) mode register write clears counter
// (R22) counter 21 bits, overflow by code and source, cleared at reset
module plw_watchdog
   import plw_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RESET_N,
   input wire logic NONSTOP_OPT,
   input wire logic [15:0] BUS_ADDR,
   input wire logic [7:0] BUS_WDATA,
   input wire logic BUS_WR,
   input wire logic BUS_RD,
   input wire logic BUS_BITOP,
   output logic [7:0] BUS_RDATA,
   output logic BUS_WAIT,
   input wire logic OSC_TICK_IN,
   input wire logic XTAL_TICK_IN,
   input wire logic XTAL_STOPPED,
   input wire logic STANDBY,
   input wire logic OSC_STAB,
   input wire logic CPU_ON_XTAL,
   input wire logic OSC_SW_STOP,
   input wire logic SUB_CLK_CPU,
   output logic INT_RESET,
   output logic CAUSE_FLAG
);
   logic [7:0] mode_ff;
   logic mode_written_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic pend_ff;
   logic [1:0] pulse_ff;
   logic cause_ff;
   logic [7:0] rdata_ff;
   logic wait_ff;
   plw_state_type state_ff;
   plw_state_type nxt_state;
   logic osc_rise;
   logic xtal_rise;

   // source ticks are asynchronous pins
   plw_edge u_osc (
      .clk(CLOCK),
      .rst_n(RESET_N),
      .async_in(OSC_TICK_IN),
      .rise(osc_rise)
   );
   plw_edge u_xtal (
      .clk(CLOCK),
      .rst_n(RESET_N),
      .async_in(XTAL_TICK_IN),
      .rise(xtal_rise)
   );

   // overflow bit index from base exponent and interval code
   function automatic logic [4:0] ovf_bit(input logic [4:0] base,
                                          input logic [2:0] code);
      ovf_bit = base + {2'h0, code};
   endfunction

   // address decode
   wire sel_mode = (BUS_ADDR == MODE_ADDR);
   wire sel_key = (BUS_ADDR == KEY_ADDR);
   wire mode_wr = BUS_WR & sel_mode;
   wire key_wr = BUS_WR & sel_key;

   // (R05) source bit picks the crystal, stop bit handled below
   // (R12) oscillator forced under the non-stoppable option
   wire use_xtal = ~NONSTOP_OPT & mode_ff[SRC_BIT];
   // (R13) (R15) (R16) source gating; never when non-stoppable
   wire gated = ~NONSTOP_OPT & (use_xtal ?
                (XTAL_STOPPED | STANDBY | OSC_STAB) :
                (STANDBY | (CPU_ON_XTAL & OSC_SW_STOP)));
   wire src_tick = use_xtal ? xtal_rise : osc_rise;
   wire tick = src_tick & ~gated;

   // (R03) (R04) (R22) overflow position by source and code
   wire [4:0] ovf_idx = ovf_bit(use_xtal ? XTAL_EXP_BASE : OSC_EXP_BASE,
                                mode_ff[IVL_MSB:0]);
   wire overflow = cnt_ff[ovf_idx];

   // (R08) (R19) reset-causing bus events; bit access to key also bad
   wire bad_mode_wr = mode_wr & mode_written_ff;
   wire bad_key_wr = key_wr & (BUS_BITOP | (BUS_WDATA != RESTART_KEY));
   wire running = (state_ff == ST_RUN);
   // (R14) stopped watchdog ignores all reset causes
   wire cause_evt = running & (overflow | bad_mode_wr | bad_key_wr);
   // (R09) pending event fires only once the source clock is ungated
   wire fire_now = (cause_evt | pend_ff) & ~gated;

   // (R11) top bits forced to 011 in the non-stoppable variant
   wire [7:0] mode_wval = NONSTOP_OPT ?
                          {FIXED_TOP, BUS_WDATA[STOP_BIT:0]} : BUS_WDATA;

   // state transitions
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_RUN: begin
            if (fire_now) begin
               nxt_state = ST_FIRE;
            end else if (mode_wr & ~mode_written_ff & ~NONSTOP_OPT &
                         BUS_WDATA[STOP_BIT]) begin
               nxt_state = ST_STOPPED;
            end
         end
         ST_STOPPED: nxt_state = ST_STOPPED;
         ST_FIRE: begin
            if (pulse_ff == 2'h0) begin
               nxt_state = ST_RUN;
            end
         end
         default: nxt_state = ST_RUN;
      endcase
   end

   // (R06) (R07) registers; run state from reset
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         state_ff <= ST_RUN;
         mode_ff <= MODE_RESET;
         mode_written_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         // (R08) only the first write lands
         if (mode_wr & ~mode_written_ff) begin
            mode_ff <= mode_wval;
            mode_written_ff <= 1'b1;
         end
      end
   end

   // counter: cleared by key, mode write, internal reset pulse; frozen stopped
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         cnt_ff <= '0;
      end else if ((key_wr & ~bad_key_wr) | mode_wr |
                   (state_ff == ST_FIRE)) begin
         // (R18) (R21) restart from zero
         cnt_ff <= '0;
      end else if (running & tick & ~overflow) begin
         // (R13) counts each ungated source tick while running, until overflow
         cnt_ff <= cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   // pending event latch and reset pulse
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         pend_ff <= 1'b0;
         pulse_ff <= 2'h0;
      end else begin
         // (R09) hold event while gated
         pend_ff <= running & (cause_evt | pend_ff) & gated;
         if (running & fire_now) begin
            pulse_ff <= RST_PULSE_LEN;
         end else if (pulse_ff != 2'h0) begin
            pulse_ff <= pulse_ff - 2'h1;
         end
      end
   end

   // cause flag is not cleared by its own internal reset
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         cause_ff <= 1'b0;
      end else if (running & fire_now) begin
         // (R02) record watchdog as reset cause
         cause_ff <= 1'b1;
      end
   end

   // read data and wait cycle
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         rdata_ff <= 8'h00;
         wait_ff <= 1'b0;
      end else begin
         if (BUS_RD & sel_mode) begin
            rdata_ff <= mode_ff;
         end else if (BUS_RD & sel_key) begin
            // (R20) fixed read value
            rdata_ff <= KEY_READ_VAL;
         end else begin
            rdata_ff <= 8'h00;
         end
         // (R17) one wait cycle per mode write
         wait_ff <= mode_wr;
      end
   end

   // (R01) internal reset while the pulse runs
   assign INT_RESET = (state_ff == ST_FIRE);
   assign CAUSE_FLAG = cause_ff;
   assign BUS_RDATA = rdata_ff;
   assign BUS_WAIT = wait_ff;

   // the flag lives at bit 4 of the cause register outside
   wire [7:0] cause_reg_view = 8'(cause_ff) << CAUSE_BIT;

   chk_wrong_key_fires: assert property ( // (R19)
      @(posedge CLOCK) disable iff (!RESET_N)
      (running & bad_key_wr & ~gated) |=> INT_RESET)
      else $error("wrong key did not reset");
   chk_stop_holds: assert property ( // (R14)
      @(posedge CLOCK) disable iff (!RESET_N)
      (state_ff == ST_STOPPED) |=> (state_ff == ST_STOPPED) && !INT_RESET)
      else $error("stopped watchdog left stop");
   chk_nonstop_runs: assert property ( // (R13)
      @(posedge CLOCK) disable iff (!RESET_N)
      NONSTOP_OPT |-> state_ff != ST_STOPPED)
      else $error("non-stoppable watchdog stopped");
   chk_gated_defer: assert property ( // (R09)
      @(posedge CLOCK) disable iff (!RESET_N)
      (running & gated) |=> !INT_RESET)
      else $error("reset issued while gated");
   chk_key_clears: assert property ( // (R18)
      @(posedge CLOCK) disable iff (!RESET_N)
      (key_wr & ~bad_key_wr) |=> cnt_ff == '0)
      else $error("key did not clear counter");
   chk_mode_clears: assert property ( // (R21)
      @(posedge CLOCK) disable iff (!RESET_N)
      mode_wr |=> cnt_ff == '0)
      else $error("mode write did not clear counter");
   chk_second_write: assert property ( // (R08)
      @(posedge CLOCK) disable iff (!RESET_N)
      (running & bad_mode_wr & ~gated) |=> INT_RESET ##0 $stable(mode_ff))
      else $error("second mode write mishandled");
   chk_cause_set: assert property ( // (R02)
      @(posedge CLOCK) disable iff (!RESET_N)
      $rose(INT_RESET) |-> cause_reg_view[CAUSE_BIT])
      else $error("cause flag not set");
   chk_pulse_len: assert property ( // (R01)
      @(posedge CLOCK) disable iff (!RESET_N)
      $rose(INT_RESET) |-> INT_RESET [*4] ##1 !INT_RESET)
      else $error("reset pulse length wrong");

   // counting, gating and bus answers
   chk_nonstop_ungated: assert property ( // (R13)
      @(posedge CLOCK) disable iff (!RESET_N)
      NONSTOP_OPT |-> !gated)
      else $error("non-stoppable watchdog gated");
   chk_overflow_fires: assert property ( // (R01)
      @(posedge CLOCK) disable iff (!RESET_N)
      (running & overflow & ~gated) |=> INT_RESET)
      else $error("overflow did not reset");
   chk_osc_forced: assert property ( // (R12)
      @(posedge CLOCK) disable iff (!RESET_N)
      NONSTOP_OPT |-> !use_xtal)
      else $error("crystal used when non-stoppable");
   chk_mode_wait: assert property ( // (R17)
      @(posedge CLOCK) disable iff (!RESET_N)
      mode_wr |=> BUS_WAIT)
      else $error("mode write inserted no wait");
   chk_key_readback: assert property ( // (R20)
      @(posedge CLOCK) disable iff (!RESET_N)
      (BUS_RD & sel_key) |=> BUS_RDATA == KEY_READ_VAL)
      else $error("key register read value wrong");
   chk_mode_frozen: assert property ( // (R08)
      @(posedge CLOCK) disable iff (!RESET_N)
      mode_written_ff |=> $stable(mode_ff))
      else $error("mode register changed after first write");
   chk_cause_sticky: assert property ( // (R02)
      @(posedge CLOCK) disable iff (!RESET_N)
      CAUSE_FLAG |=> CAUSE_FLAG)
      else $error("cause flag cleared");
   chk_gated_frozen: assert property ( // (R15)
      @(posedge CLOCK) disable iff (!RESET_N)
      (running & gated & ~mode_wr & ~key_wr) |=> $stable(cnt_ff))
      else $error("counter moved while gated");
   chk_stop_frozen: assert property ( // (R14)
      @(posedge CLOCK) disable iff (!RESET_N)
      ((state_ff == ST_STOPPED) & ~mode_wr & ~key_wr) |=> $stable(cnt_ff))
      else $error("stopped counter moved");
   chk_count_step: assert property ( // (R22)
      @(posedge CLOCK) disable iff (!RESET_N)
      (running & tick & ~overflow & ~mode_wr & ~key_wr) |=>
      cnt_ff == $past(cnt_ff) + {{(CNT_W-1){1'b0}}, 1'b1})
      else $error("counter did not step");
   chk_fire_clears: assert property ( // (R22)
      @(posedge CLOCK) disable iff (!RESET_N)
      (state_ff == ST_FIRE) |=> cnt_ff == '0)
      else $error("counter not cleared by reset pulse");
endmodule

/* plw_pkg.sv */
package plw_pkg;
   // cpu bus addresses of the two watchdog registers
   localparam logic [15:0] MODE_ADDR = 16'hFF98;
   localparam logic [15:0] KEY_ADDR = 16'hFF99;
   // reset, read and restart key values
   localparam logic [7:0] MODE_RESET = 8'h67;
   localparam logic [7:0] KEY_READ_VAL = 8'h9A;
   localparam logic [7:0] RESTART_KEY = 8'hAC;
   // mode register field positions, cause flag bit and fixed top bits
   localparam int STOP_BIT = 4;
   localparam int SRC_BIT = 3;
   localparam int IVL_MSB = 2;
   localparam int CAUSE_BIT = 4;
   localparam logic [2:0] FIXED_TOP = 3'h3;
   // overflow exponent bases per source
   localparam logic [4:0] OSC_EXP_BASE = 5'h0B;
   localparam logic [4:0] XTAL_EXP_BASE = 5'h0D;
   localparam int CNT_W = 21;
   // one less than the count of cycles the internal reset pulse is held
   localparam logic [1:0] RST_PULSE_LEN = 2'h3;

   typedef enum logic [2:0] {
      ST_RUN = 3'h1,
      ST_STOPPED = 3'h2,
      ST_FIRE = 3'h4
   } plw_state_type;
endpackage

/* plw_edge.sv */
`timescale 1ns/1ps
// two-flop synchroniser followed by a rising edge detector
module plw_edge (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic async_in,
   output logic rise
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;

   // only s2_ff and s3_ff feed the edge gate
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
      end else begin
         s1_ff <= async_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   assign rise = s2_ff & ~s3_ff;
endmodule

/* program_loop_watchdog_tb.sv */
`timescale 1ns/1ps
module program_loop_watchdog_tb import plw_pkg::*;;
   logic clock, reset_n, nonstop, bus_wr, bus_rd, bus_bitop;
   logic standby, xtal_stopped, bus_wait, int_reset, cause_flag;
   logic osc_tick, xtal_tick, seen;
   logic osc_stab, cpu_on_xtal, osc_sw_stop;
   logic [15:0] bus_addr;
   logic [7:0] bus_wdata, bus_rdata, rd_val;
   logic [1:0] tick_div;
   int mismatches, checks;

   // sub clock cpu held low: software never writes mode then
   plw_watchdog dut_u (.CLOCK(clock), .RESET_N(reset_n),
      .NONSTOP_OPT(nonstop), .BUS_ADDR(bus_addr), .BUS_WDATA(bus_wdata),
      .BUS_WR(bus_wr), .BUS_RD(bus_rd), .BUS_BITOP(bus_bitop),
      .BUS_RDATA(bus_rdata), .BUS_WAIT(bus_wait), .OSC_TICK_IN(osc_tick),
      .XTAL_TICK_IN(xtal_tick), .XTAL_STOPPED(xtal_stopped),
      .STANDBY(standby), .OSC_STAB(osc_stab), .CPU_ON_XTAL(cpu_on_xtal),
      .OSC_SW_STOP(osc_sw_stop), .SUB_CLK_CPU(1'b0), .INT_RESET(int_reset),
      .CAUSE_FLAG(cause_flag));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // tick pins: four clocks a tick, slow enough for the synchroniser
   always @(posedge clock) begin
      tick_div <= tick_div + 2'h1;
      osc_tick <= tick_div[1];
      xtal_tick <= ~tick_div[1];
   end

   task check(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task finish_test;
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task wr(input logic [15:0] a, input logic [7:0] d, input logic bop);
      @(posedge clock);
      bus_addr <= a;
      bus_wdata <= d;
      bus_bitop <= bop;
      bus_wr <= 1'b1;
      @(posedge clock);
      bus_wr <= 1'b0;
      bus_bitop <= 1'b0;
      #1;
   endtask

   task rd(input logic [15:0] a);
      @(posedge clock);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clock);
      bus_rd <= 1'b0;
      #1 rd_val = bus_rdata;
   endtask

   // notes whether the internal reset showed at all over n cycles
   task watch(input int n);
      seen = 1'b0;
      repeat (n) begin
         @(posedge clock);
         #1;
         if (int_reset === 1'b1)
            seen = 1'b1;
      end
   endtask

   task do_reset(input logic ns);
      @(posedge clock);
      nonstop <= ns;
      reset_n <= 1'b0;
      repeat (3) @(posedge clock);
      reset_n <= 1'b1;
      #1;
   endtask

   task t_regs;
      do_reset(1'b0);
      check(cause_flag, 8'h00);
      rd(MODE_ADDR);
      check(rd_val, MODE_RESET);
      rd(KEY_ADDR);
      check(rd_val, KEY_READ_VAL);
      rd(16'hFF97);
      check(rd_val, 8'h00);
      wr(MODE_ADDR, 8'h60, 1'b0); // byte write, top bits 011
      check(bus_wait, 8'h01);
      rd(MODE_ADDR);
      check(rd_val, 8'h60);
      watch(8150);
      check(seen, 8'h00);
      watch(100);
      check(seen, 8'h01);
      check(cause_flag, 8'h01);
      $display("test regs done");
   endtask

   task t_key;
      do_reset(1'b0);
      wr(MODE_ADDR, 8'h60, 1'b0);
      watch(6000);
      wr(KEY_ADDR, RESTART_KEY, 1'b0);
      watch(6000);
      check(seen, 8'h00);
      wr(KEY_ADDR, 8'h55, 1'b0);
      watch(3);
      check(seen, 8'h01);
      watch(10);
      wr(KEY_ADDR, RESTART_KEY, 1'b1);
      watch(3);
      check(seen, 8'h01);
      $display("test key done");
   endtask

   task t_second;
      do_reset(1'b0);
      wr(MODE_ADDR, 8'h60, 1'b0);
      wr(MODE_ADDR, 8'h61, 1'b0);
      watch(3);
      check(seen, 8'h01);
      rd(MODE_ADDR);
      check(rd_val, 8'h60);
      $display("test second write done");
   endtask

   task t_stop;
      do_reset(1'b0);
      wr(MODE_ADDR, 8'h70, 1'b0);
      wr(MODE_ADDR, 8'h60, 1'b0);
      wr(KEY_ADDR, 8'h55, 1'b0);
      watch(9000);
      check(seen, 8'h00);
      $display("test stop done");
   endtask

   // stop, crystal and standby gating must all be ignored here
   task t_nonstop;
      do_reset(1'b1);
      wr(MODE_ADDR, 8'h78, 1'b0);
      watch(8150);
      check(seen, 8'h00);
      watch(100);
      check(seen, 8'h01);
      watch(10);
      @(posedge clock) standby <= 1'b1;
      wr(KEY_ADDR, 8'h55, 1'b0);
      watch(3);
      check(seen, 8'h01);
      @(posedge clock) standby <= 1'b0;
      $display("test nonstop done");
   endtask

   task t_xtal;
      do_reset(1'b0);
      wr(MODE_ADDR, 8'h68, 1'b0);
      watch(32700);
      check(seen, 8'h00);
      watch(100);
      check(seen, 8'h01);
      watch(10);
      @(posedge clock) standby <= 1'b1;
      wr(KEY_ADDR, 8'h55, 1'b0);
      watch(20);
      check(seen, 8'h00);
      @(posedge clock) standby <= 1'b0;
      watch(6);
      check(seen, 8'h01);
      watch(10);
      @(posedge clock) xtal_stopped <= 1'b1;
      wr(KEY_ADDR, 8'h55, 1'b0);
      watch(20);
      check(seen, 8'h00);
      @(posedge clock) xtal_stopped <= 1'b0;
      watch(6);
      check(seen, 8'h01);
      watch(10);
      @(posedge clock) osc_stab <= 1'b1;
      wr(KEY_ADDR, 8'h55, 1'b0);
      watch(20);
      check(seen, 8'h00);
      @(posedge clock) osc_stab <= 1'b0;
      watch(6);
      check(seen, 8'h01);
      $display("test crystal done");
   endtask

   // oscillator source: standby gates, and cpu on crystal with osc stopped
   task t_oscgate;
      do_reset(1'b0);
      @(posedge clock) standby <= 1'b1;
      wr(KEY_ADDR, 8'h55, 1'b0);
      watch(20);
      check(seen, 8'h00);
      @(posedge clock) standby <= 1'b0;
      watch(6);
      check(seen, 8'h01);
      watch(10);
      @(posedge clock) cpu_on_xtal <= 1'b1;
      wr(KEY_ADDR, 8'h55, 1'b0);
      watch(3);
      check(seen, 8'h01);
      watch(10);
      @(posedge clock) osc_sw_stop <= 1'b1;
      wr(KEY_ADDR, 8'h55, 1'b0);
      watch(20);
      check(seen, 8'h00);
      @(posedge clock) osc_sw_stop <= 1'b0;
      watch(6);
      check(seen, 8'h01);
      @(posedge clock) cpu_on_xtal <= 1'b0;
      $display("test oscillator gating done");
   endtask

   // a hang counts as a mismatch; the run needs about 71k cycles
   initial begin
      #950000;
      mismatches++;
      finish_test;
   end

   initial begin
      {reset_n, nonstop, bus_wr, bus_rd, bus_bitop} = 5'h00;
      {standby, xtal_stopped, osc_tick, xtal_tick} = 4'h0;
      {osc_stab, cpu_on_xtal, osc_sw_stop} = 3'h0;
      bus_addr = 16'h0000;
      bus_wdata = 8'h00;
      tick_div = 2'h0;
      mismatches = 0;
      checks = 0;
      t_regs;
      t_key;
      t_second;
      t_stop;
      t_nonstop;
      t_xtal;
      t_oscgate;
      finish_test;
   end
endmodule
